// ===== adc_conv_timer.sv
// Conversion timing controller of a successive-approximation converter, AHB-Lite slave
// Notes on behaviour
// - In compatibility mode the divider field 00/01/10/11 divides the system clock by 4/2/16/8.
// - In compatibility mode the sample field 00/01/10/11 gives 8/16/32/64 basic clock periods.
// - A 10-bit conversion takes 52 (post-calibration) or 40 basic periods plus sample time plus 6 system clocks.
// - An 8-bit conversion takes 44 (post-calibration) or 32 basic periods plus sample time plus 6 system clocks.
// - Turning post-calibration off shortens any conversion by exactly 12 basic periods.
// - A conversion is sample phase, then result determination, then a load phase, in system clocks.
// - After reset a calibration of 484 to 11,696 basic periods runs before calibration is complete.
// - Conversions requested during reset calibration are accepted and lengthen the calibration.
// - An input below ground gives 000 and above reference supply gives 3FF.
// - All system-period terms count the system clock, equal in rate to the CPU clock.
// - An improved input clock scheme, chosen by a configuration bit, replaces the two-bit divider.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
module adc_conv_timer
  import adc_timing_pkg::*;
#(
  parameter int CAL_EXTRA_BC = 0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [9:0] core_code,
  input wire logic core_under,
  input wire logic core_over,
  output logic core_sample,
  output logic core_convert
);
  import adc_timing_pkg::*;

  typedef enum {S_IDLE, S_SAMPLE, S_CONVERT, S_LOAD} phase_t;

  // ====================================================================
  // Bus slave
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic start_req;
  logic done_clr;
  logic addr_phase;

  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    wr_pend_next = addr_phase && hwrite;
    addr_next = addr_phase ? haddr[7:0] : addr_reg;
    ctrl_next = ctrl_reg;
    start_req = 1'b0;
    done_clr = 1'b0;
    if (wr_pend_reg) begin
      unique case (addr_reg)
        CTRL_OFS: ctrl_next = hwdata[15:0];
        START_OFS: start_req = hwdata[0];
        STATUS_OFS: done_clr = hwdata[2];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      ctrl_reg <= CTRL_RESET;
    end else begin
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // ====================================================================
  // Basic clock selection
  logic [1:0] div_sel, smp_sel;
  logic [7:0] div_val;
  logic [7:0] smp_bc;
  logic bc_tick;
  logic busy;
  logic conv_start;

  assign div_sel = ctrl_reg[DIV_SEL_POS +: 2];
  assign smp_sel = ctrl_reg[SMP_SEL_POS +: 2];

  always_comb begin
    if (ctrl_reg[IMPROVED_POS]) begin
      div_val = {ctrl_reg[IMP_DIV_POS +: 6], 2'b00} | 8'h01;
    end else begin
      unique case (div_sel)
        2'b00: div_val = 8'h04;
        2'b01: div_val = 8'h02;
        2'b10: div_val = 8'h10;
        2'b11: div_val = 8'h08;
      endcase
    end
    unique case (smp_sel)
      2'b00: smp_bc = 8'h08;
      2'b01: smp_bc = 8'h10;
      2'b10: smp_bc = 8'h20;
      2'b11: smp_bc = 8'h40;
    endcase
  end

  // System clock drives the prescaler directly: CPU-rate clock
  bc_divider #(.W(8)) u_div (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(busy && !conv_start),
    .div(div_val),
    .tick(bc_tick)
  );

  // ====================================================================
  // Calibration and conversion sequencer
  phase_t phase_reg, phase_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] cal_reg, cal_next;
  logic cal_busy_reg, cal_busy_next;
  logic pend_reg, pend_next;
  logic done_reg, done_next;
  logic [9:0] result_reg, result_next;
  logic [9:0] clipped;
  logic [7:0] det_bc;

  always_comb begin
    unique case ({ctrl_reg[RES8_POS], ctrl_reg[POSTCAL_POS]})
      2'b01: det_bc = 8'(BC_P10_CAL);
      2'b00: det_bc = 8'(BC_P10_NOCAL);
      2'b11: det_bc = 8'(BC_P8_CAL);
      2'b10: det_bc = 8'(BC_P8_NOCAL);
    endcase
    if (core_under) begin
      clipped = 10'h000;
    end else if (core_over) begin
      clipped = 10'(FULL_SCALE);
    end else if (ctrl_reg[RES8_POS]) begin
      clipped = {core_code[9:2], 2'b00};
    end else begin
      clipped = core_code;
    end
  end

  assign busy = cal_busy_reg || (phase_reg != S_IDLE);
  // A free-running prescaler would clip the first sample period; restart it as a conversion begins
  assign conv_start = (phase_reg == S_IDLE) && pend_reg;

  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    cal_next = cal_reg;
    cal_busy_next = cal_busy_reg;
    pend_next = pend_reg || start_req;
    done_next = done_reg && !done_clr;
    result_next = result_reg;
    // Calibration counts basic ticks; a conversion pauses it, which lengthens it
    if (cal_busy_reg && phase_reg == S_IDLE && bc_tick) begin
      if (cal_reg >= 16'(CAL_MIN_BC + CAL_EXTRA_BC) - 16'h0001) begin
        cal_busy_next = 1'b0;
      end
      cal_next = cal_reg + 16'h0001;
    end
    unique case (phase_reg)
      S_IDLE: begin
        if (pend_reg) begin
          pend_next = start_req;
          phase_next = S_SAMPLE;
          cnt_next = 16'(smp_bc);
        end
      end
      S_SAMPLE: begin
        if (bc_tick) begin
          cnt_next = cnt_reg - 16'h0001;
          if (cnt_reg == 16'h0001) begin
            phase_next = S_CONVERT;
            cnt_next = 16'(det_bc);
          end
        end
      end
      S_CONVERT: begin
        if (bc_tick) begin
          cnt_next = cnt_reg - 16'h0001;
          if (cnt_reg == 16'h0001) begin
            phase_next = S_LOAD;
            cnt_next = 16'(LOAD_SYS);
          end
        end
      end
      S_LOAD: begin
        cnt_next = cnt_reg - 16'h0001;
        if (cnt_reg == 16'h0001) begin
          phase_next = S_IDLE;
          result_next = clipped;
          done_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_reg <= S_IDLE;
      cnt_reg <= 16'h0000;
      cal_reg <= 16'h0000;
      cal_busy_reg <= 1'b1;
      pend_reg <= 1'b0;
      done_reg <= 1'b0;
      result_reg <= 10'h000;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      cal_reg <= cal_next;
      cal_busy_reg <= cal_busy_next;
      pend_reg <= pend_next;
      done_reg <= done_next;
      result_reg <= result_next;
    end
  end

  // ====================================================================
  // Read data and core strobes
  logic sample_reg, convert_reg;

  always_comb begin
    hrdata_next = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        CTRL_OFS: hrdata_next = {16'h0000, ctrl_reg};
        STATUS_OFS: hrdata_next = {29'h0, done_reg, cal_busy_reg, phase_reg != S_IDLE};
        RESULT_OFS: hrdata_next = {22'h0, result_reg};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hrdata_reg <= 32'h0000_0000;
      sample_reg <= 1'b0;
      convert_reg <= 1'b0;
    end else begin
      hrdata_reg <= hrdata_next;
      sample_reg <= phase_next == S_SAMPLE;
      convert_reg <= phase_next == S_CONVERT;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign core_sample = sample_reg;
  assign core_convert = convert_reg;

  // ====================================================================
  // Checks
  a_load_six_cycles: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (phase_reg == S_CONVERT && phase_next == S_LOAD) |=> (phase_reg == S_LOAD) [*6] ##1 done_reg)
    else $error("load phase not six cycles");
  a_done_with_result: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(done_reg) |-> $changed(result_reg) || result_reg == $past(clipped))
    else $error("done without result load");
  a_over_clips: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (phase_reg == S_LOAD && cnt_reg == 16'h0001 && core_over && !core_under) |=> result_reg == 10'h3FF)
    else $error("over-range not clipped");
  a_under_clips: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (phase_reg == S_LOAD && cnt_reg == 16'h0001 && core_under) |=> result_reg == 10'h000)
    else $error("under-range not zero");
  a_div_by_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (bc_tick && (phase_reg == S_SAMPLE || phase_reg == S_CONVERT) && !ctrl_reg[IMPROVED_POS] && div_sel == 2'b01
      && $stable(ctrl_reg)) |=> !bc_tick ##1 bc_tick)
    else $error("divide by two wrong");
  a_tick_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (conv_start && div_val != 8'h01) |=> !bc_tick)
    else $error("prescaler not restarted at conversion start");
  a_sample_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (phase_reg == S_IDLE && pend_reg) |=> cnt_reg == 16'(smp_bc))
    else $error("sample length wrong");
  a_postcal_diff: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (phase_reg == S_SAMPLE && phase_next == S_CONVERT && !ctrl_reg[POSTCAL_POS] && !ctrl_reg[RES8_POS])
      |=> cnt_reg == 16'(BC_P10_CAL - 12))
    else $error("post-calibration saving wrong");
  a_cal_paused: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cal_busy_reg && phase_reg != S_IDLE) |=> $stable(cal_reg))
    else $error("calibration advanced during conversion");
  a_cal_min: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(cal_busy_reg) |-> cal_reg >= 16'(CAL_MIN_BC))
    else $error("calibration too short");
  c_conv_done: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(done_reg));
  c_conv_in_cal: cover property (@(posedge sys_clk) disable iff (sys_rst) cal_busy_reg && phase_reg == S_SAMPLE);
  c_cal_end: cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(cal_busy_reg));
  c_improved_conv: cover property (@(posedge sys_clk) disable iff (sys_rst) phase_reg == S_CONVERT && ctrl_reg[IMPROVED_POS]);
endmodule : adc_conv_timer

// ===== adc_timing_pkg.sv
// Package: register map, field layout and timing constants of the conversion timer
package adc_timing_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] START_OFS = 8'h0C;
  localparam int DIV_SEL_POS = 14;
  localparam int SMP_SEL_POS = 12;
  localparam int IMPROVED_POS = 11;
  localparam int POSTCAL_POS = 10;
  localparam int RES8_POS = 9;
  localparam int IMP_DIV_POS = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0400;
  localparam int BC_P10_CAL = 52;
  localparam int BC_P10_NOCAL = 40;
  localparam int BC_P8_CAL = 44;
  localparam int BC_P8_NOCAL = 32;
  localparam int LOAD_SYS = 6;
  localparam int CAL_MIN_BC = 484;
  localparam int CAL_MAX_BC = 11696;
  localparam int FULL_SCALE = 10'h3FF;
  localparam int SYS_CLK_MHZ = 10;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic busy;
    logic cal_busy;
    logic done;
    logic [9:0] result;
  } conv_stat_t;
endpackage : adc_timing_pkg

// ===== bc_divider.sv
// Basic clock prescaler: one-cycle tick every div system clocks
module bc_divider #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      // Restart one count ahead: the tick flop adds a cycle, so the first tick still lands div clocks on
      cnt_next = W'(1);
      tick_next = (div == W'(1));
    end else if (cnt_reg >= div - W'(1)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : bc_divider

// ===== adc_core_model.sv
// Stand-in for the analog core: preset code and range flags during conversions
module adc_core_model (
  input wire logic sys_clk,
  input wire logic core_convert,
  input wire logic [9:0] set_code,
  input wire logic set_under,
  input wire logic set_over,
  output logic [9:0] core_code,
  output logic core_under,
  output logic core_over
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold = 0;
  initial core_code = 10'h000;
  // ==========================================
  // Outputs valid through determination and load only
  // Outside that window the flags are inverted and the code toggles every clock, so a late sample gives a wrong result
  always @(posedge sys_clk) begin
    hold <= core_convert ? 8 : (hold > 0 ? hold - 1 : 0);
    core_code <= (core_convert || hold > 0) ? set_code : ~core_code;
    core_under <= (core_convert || hold > 0) ? set_under : ~set_under;
    core_over <= (core_convert || hold > 0) ? set_over : ~set_over;
  end
endmodule : adc_core_model

// ===== adc_conversion_timing_test.sv
// Testbench of the conversion timer: registers, phase lengths, calibration, results
module adc_conversion_timing_test;
  import adc_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, set_under = 0, set_over = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] set_code = 0, core_code;
  logic hready, hresp, core_under, core_over, core_sample, core_convert;
  int err_count = 0, checks = 0, cyc = 0, rel = 0, seed = 38859;
  logic [31:0] exp_q[$];
  adc_conv_timer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .core_code(core_code), .core_under(core_under), .core_over(core_over),
    .core_sample(core_sample), .core_convert(core_convert));
  adc_core_model core (.sys_clk(sys_clk), .core_convert(core_convert), .set_code(set_code),
    .set_under(set_under), .set_over(set_over), .core_code(core_code), .core_under(core_under),
    .core_over(core_over));
  initial forever #50 sys_clk = ~sys_clk;
  // ==========================================
  // Timeout
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 60000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // ==========================================
  // AHB-Lite single word transfer; entered right after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic phase_len(input int sel, output int c);
    c = 0;
    // Both phases are registered levels counted in system clocks
    while ((sel ? core_convert : core_sample) !== 1'b1 && c < 3) begin
      @(negedge sys_clk);
      c++;
    end
    c = 0;
    while ((sel ? core_convert : core_sample) === 1'b1 && c < 5000) begin
      @(negedge sys_clk);
      c++;
    end
  endtask : phase_len
  task automatic conv(input int ds, input int ss, input int imp, input int pc, input int r8, input int uo,
      input logic cb);
    int dv, ns, nd, c;
    logic [31:0] ex;
    dv = imp != 0 ? imp * 4 + 1 : (ds == 0 ? 4 : ds == 1 ? 2 : ds == 2 ? 16 : 8);
    ns = 8 << ss;
    nd = r8 ? (pc ? 44 : 32) : (pc ? 52 : 40);
    set_code <= 10'($random(seed));
    set_under <= uo == 1;
    set_over <= uo == 2;
    bus(1'b1, CTRL_OFS, 32'(ds << 14 | ss << 12 | (imp != 0) << 11 | pc << 10 | r8 << 9 | imp));
    bus(1'b1, START_OFS, 32'h00000001);
    ex = uo == 1 ? 32'h0 : uo == 2 ? 32'h3FF : r8 ? {22'h0, set_code[9:2], 2'h0} : {22'h0, set_code};
    exp_q.push_back(ex);
    while (core_sample !== 1'b1 && cyc < 60000) @(negedge sys_clk);
    phase_len(0, c);
    check("sample_len", c, ns * dv);
    phase_len(1, c);
    check("determ_len", c, nd * dv);
    @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 0);
    check("status_load", r, {29'h0, 1'b0, cb, 1'b1});
    repeat (6) @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 0);
    check("status_done", r, {29'h0, 1'b1, cb, 1'b0});
    bus(1'b0, RESULT_OFS, 0);
    check("result", r, exp_q.pop_front());
    bus(1'b1, STATUS_OFS, 32'h4);
    bus(1'b0, STATUS_OFS, 0);
    check("status_clear", r & 32'h5, 32'h0);
  endtask : conv
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rel = cyc;
    bus(1'b0, CTRL_OFS, 0);
    check("ctrl_reset", r, {16'h0, CTRL_RESET});
    bus(1'b0, STATUS_OFS, 0);
    check("cal_running", r, 32'h2);
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 0);
    check("unmapped", r, 32'h0);
    conv(0, 0, 0, 1, 0, 0, 1'b1);
    while (cyc < rel + 484 * 4 + 40) @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 0);
    check("cal_extended", r[1], 1'b1);
    while (cyc < rel + 484 * 4 + 246 + 40) @(posedge sys_clk);
    bus(1'b0, STATUS_OFS, 0);
    check("cal_complete", r[1], 1'b0);
    for (int i = 0; i < 8; i++) begin
      conv(i & 3, (i >> 1) & 3, 0, $random(seed) & 1, i > 2 ? $random(seed) & 1 : 0, i < 3 ? i : 0, 1'b0);
    end
    conv(0, 1, 3, 0, 1, 0, 1'b0);
    final_report();
  end
endmodule : adc_conversion_timing_test
